// ===== hw/pwmcc_top.sv
// PWM counter readback and dual comparator stage with APB registers
// Notes on behaviour
// - Each generator compares its counter against two compare values and pulses one cycle on match.
// - A committed compare value above the committed load value never produces a match pulse.
// - In immediate mode the first compare value goes live at the next counter zero.
// - A control bit per generator picks immediate or synchronous update for the first comparator.
// - The second comparator has its own mode bit and behaves the same way.
// - In synchronous mode a pending value commits at the first zero after a master update request.
// - A rewrite before commit discards the earlier pending value; only the latest is used.
// - Three generators exist, first compare registers at 0x058, 0x098 and 0x0d8.
// - The counter also pulses one cycle at the load value and at zero.
// - The load value is reloaded after zero in down mode, or is the turning point in up/down mode.
`timescale 1ns/1ps
`default_nettype none
module pwmcc_top
    import pwmcc_pkg::*;
(
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               reset_n,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [DATA_W-1:0]  pwdata,
    output logic [DATA_W-1:0]       prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Event pulses, one bit per generator
    output logic [NUM_GEN-1:0]      zero_pulse,
    output logic [NUM_GEN-1:0]      load_pulse,
    output logic [NUM_GEN-1:0]      cmp1_pulse,
    output logic [NUM_GEN-1:0]      cmp2_pulse,
    // Interrupt
    output logic                    irq
);

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic [1:0] blk_of(input logic [ADDR_W-1:0] a);
        blk_of = a[BLK_MSB:BLK_LSB];
    endfunction

    function automatic logic [5:0] ofs_of(input logic [ADDR_W-1:0] a);
        ofs_of = a[OFS_MSB:0];
    endfunction

    function automatic logic [DATA_W-1:0] zext(input logic [CNT_W-1:0] v);
        zext = {{(DATA_W-CNT_W){1'b0}}, v};
    endfunction

    wire [1:0] blk      = blk_of(paddr);
    wire [5:0] ofs      = ofs_of(paddr);
    wire       hi_zero  = (paddr[ADDR_W-1:BLK_MSB+1] == '0);
    wire       is_glob  = hi_zero && (blk == BLK_GLOBAL);
    wire       is_gen   = hi_zero && (blk != BLK_GLOBAL);
    wire [1:0] gsel     = blk - 2'h1;
    wire       setup    = psel && !penable;
    wire       wr_acc   = psel && penable && pwrite && !pslverr;

    wire glob_hit = is_glob && (ofs == OFS_MASTER_CTL || ofs == OFS_IRQ_STATUS
                                || ofs == OFS_IRQ_MASK);
    wire gen_hit  = is_gen && (ofs == OFS_GEN_CTL || ofs == OFS_GEN_LOAD
                               || ofs == OFS_GEN_COUNT || ofs == OFS_GEN_CMP1
                               || ofs == OFS_GEN_CMP2);
    wire mapped   = glob_hit || gen_hit;

    wire wr_master = wr_acc && is_glob && (ofs == OFS_MASTER_CTL);
    wire wr_status = wr_acc && is_glob && (ofs == OFS_IRQ_STATUS);
    wire wr_mask   = wr_acc && is_glob && (ofs == OFS_IRQ_MASK);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [CTL_W-1:0]   ctl_reg    [NUM_GEN];
    logic [NUM_GEN-1:0] sync_reg;
    logic [NUM_GEN-1:0] sync_next;
    logic [EVT_W-1:0]   status_reg;
    logic [EVT_W-1:0]   status_next;
    logic [EVT_W-1:0]   mask_reg;
    logic [DATA_W-1:0]  rdata_reg;
    logic [DATA_W-1:0]  rdata_next;

    logic [CNT_W-1:0]   count      [NUM_GEN];
    logic [CNT_W-1:0]   load_sh    [NUM_GEN];
    logic [CNT_W-1:0]   load_act   [NUM_GEN];
    logic [CNT_W-1:0]   cmp1_sh    [NUM_GEN];
    logic [CNT_W-1:0]   cmp2_sh    [NUM_GEN];
    logic [NUM_GEN-1:0] at_zero;
    logic [EVT_W-1:0]   evt;

    // ************************************************************
    // Generator instances
    // ************************************************************
    for (genvar g = 0; g < NUM_GEN; g++)
    begin : gen_inst
        wire sel_g   = is_gen && (gsel == 2'(g));
        wire wr_ctl  = wr_acc && sel_g && (ofs == OFS_GEN_CTL);
        wire wr_load = wr_acc && sel_g && (ofs == OFS_GEN_LOAD);
        // Count readback is read-only; no strobe reaches it
        wire wr_cmp1 = wr_acc && sel_g && (ofs == OFS_GEN_CMP1);
        wire wr_cmp2 = wr_acc && sel_g && (ofs == OFS_GEN_CMP2);

        always_ff @(posedge mclk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                ctl_reg[g] <= CTL_RST;
            end
            else if (wr_ctl)
            begin
                ctl_reg[g] <= pwdata[CTL_W-1:0];
            end
        end

        pwmcc_gen u_gen (
            .mclk           (mclk),
            .reset_n        (reset_n),
            .cnt_en         (ctl_reg[g][CTL_ENABLE]),
            .updown         (ctl_reg[g][CTL_UPDOWN]),
            .load_sync_mode (ctl_reg[g][CTL_LOAD_UPD]),
            .sync_armed     (sync_reg[g]),
            .wr_stb         (wr_load),
            .wr_data        (pwdata[CNT_W-1:0]),
            .count          (count[g]),
            .load_shadow    (load_sh[g]),
            .load_active    (load_act[g]),
            .at_zero        (at_zero[g]),
            .zero_pulse     (zero_pulse[g]),
            .load_pulse     (load_pulse[g])
        );

        pwmcc_cmp u_cmp1 (
            .mclk        (mclk),
            .reset_n     (reset_n),
            .wr_stb      (wr_cmp1),
            .wr_data     (pwdata[CNT_W-1:0]),
            .sync_mode   (ctl_reg[g][CTL_CMP1_UPD]),
            .sync_armed  (sync_reg[g]),
            .at_zero     (at_zero[g]),
            .cnt_en      (ctl_reg[g][CTL_ENABLE]),
            .count       (count[g]),
            .load_active (load_act[g]),
            .shadow      (cmp1_sh[g]),
            .match_pulse (cmp1_pulse[g])
        );

        pwmcc_cmp u_cmp2 (
            .mclk        (mclk),
            .reset_n     (reset_n),
            .wr_stb      (wr_cmp2),
            .wr_data     (pwdata[CNT_W-1:0]),
            .sync_mode   (ctl_reg[g][CTL_CMP2_UPD]),
            .sync_armed  (sync_reg[g]),
            .at_zero     (at_zero[g]),
            .cnt_en      (ctl_reg[g][CTL_ENABLE]),
            .count       (count[g]),
            .load_active (load_act[g]),
            .shadow      (cmp2_sh[g]),
            .match_pulse (cmp2_pulse[g])
        );

        assign evt[g*EVT_PER_G + EVT_ZERO] = zero_pulse[g];
        assign evt[g*EVT_PER_G + EVT_LOAD] = load_pulse[g];
        assign evt[g*EVT_PER_G + EVT_CMP1] = cmp1_pulse[g];
        assign evt[g*EVT_PER_G + EVT_CMP2] = cmp2_pulse[g];
    end

    // ************************************************************
    // Sync request and interrupt status
    // ************************************************************
    // Request holds until that generator's next zero; a new request wins
    assign sync_next = (sync_reg & ~at_zero)
                       | (wr_master ? pwdata[NUM_GEN-1:0] : '0);

    // Hardware set wins over a write-one clear in the same cycle
    assign status_next = (status_reg & ~(wr_status ? pwdata[EVT_W-1:0] : '0)) | evt;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_reg   <= '0;
            status_reg <= EVT_RST;
            mask_reg   <= EVT_RST;
        end
        else
        begin
            sync_reg   <= sync_next;
            status_reg <= status_next;
            if (wr_mask)
            begin
                mask_reg <= pwdata[EVT_W-1:0];
            end
        end
    end

    assign irq = |(status_reg & mask_reg);

    // ************************************************************
    // Read path
    // ************************************************************
    // Data captured in the setup cycle, so count is one cycle old
    always_comb
    begin
        rdata_next = DATA_RST;
        if (is_glob)
        begin
            unique case (ofs)
                OFS_MASTER_CTL: rdata_next = {{(DATA_W-NUM_GEN){1'b0}}, sync_reg};
                OFS_IRQ_STATUS: rdata_next = {{(DATA_W-EVT_W){1'b0}}, status_reg};
                OFS_IRQ_MASK:   rdata_next = {{(DATA_W-EVT_W){1'b0}}, mask_reg};
                default:        rdata_next = DATA_RST;
            endcase
        end
        else if (is_gen)
        begin
            unique case (ofs)
                OFS_GEN_CTL:   rdata_next = {{(DATA_W-CTL_W){1'b0}}, ctl_reg[gsel]};
                OFS_GEN_LOAD:  rdata_next = zext(load_sh[gsel]);
                OFS_GEN_COUNT: rdata_next = zext(count[gsel]);
                OFS_GEN_CMP1:  rdata_next = zext(cmp1_sh[gsel]);
                OFS_GEN_CMP2:  rdata_next = zext(cmp2_sh[gsel]);
                default:       rdata_next = DATA_RST;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_reg <= DATA_RST;
        end
        else if (setup && !pwrite)
        begin
            rdata_reg <= rdata_next;
        end
    end

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = rdata_reg;

endmodule
`default_nettype wire

// ===== hw/pwmcc_pkg.sv
// Register map, field positions and reset values for the PWM compare stage
package pwmcc_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_GEN   = 3;
    localparam int CNT_W     = 16;
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int EVT_PER_G = 4;
    localparam int EVT_W     = NUM_GEN * EVT_PER_G;

    // ************************************************************
    // Address layout
    // ************************************************************
    // Block index 0 holds the global registers, 1..3 the generators
    localparam int BLK_MSB = 7;
    localparam int BLK_LSB = 6;
    localparam int OFS_MSB = 5;

    localparam logic [1:0] BLK_GLOBAL = 2'h0;

    localparam logic [5:0] OFS_MASTER_CTL = 6'h00;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h04;
    localparam logic [5:0] OFS_IRQ_MASK   = 6'h08;

    localparam logic [5:0] OFS_GEN_CTL    = 6'h00;
    localparam logic [5:0] OFS_GEN_LOAD   = 6'h10;
    localparam logic [5:0] OFS_GEN_COUNT  = 6'h14;
    localparam logic [5:0] OFS_GEN_CMP1   = 6'h18;
    localparam logic [5:0] OFS_GEN_CMP2   = 6'h1c;

    // Full byte addresses of the compare pair, generator 0..2, plus generator 0's counter value
    localparam logic [ADDR_W-1:0] ADDR_GEN0_COUNTER_VALUE  = 12'h054;
    localparam logic [ADDR_W-1:0] ADDR_GEN0_COMPARE_FIRST  = 12'h058;
    localparam logic [ADDR_W-1:0] ADDR_GEN0_COMPARE_SECOND = 12'h05c;
    localparam logic [ADDR_W-1:0] ADDR_GEN1_COMPARE_FIRST  = 12'h098;
    localparam logic [ADDR_W-1:0] ADDR_GEN1_COMPARE_SECOND = 12'h09c;
    localparam logic [ADDR_W-1:0] ADDR_GEN2_COMPARE_FIRST  = 12'h0d8;
    localparam logic [ADDR_W-1:0] ADDR_GEN2_COMPARE_SECOND = 12'h0dc;

    // ************************************************************
    // Generator control fields
    // ************************************************************
    localparam int CTL_ENABLE     = 0;
    localparam int CTL_UPDOWN     = 1;
    localparam int CTL_LOAD_UPD   = 2;
    localparam int CTL_CMP1_UPD   = 4;
    localparam int CTL_CMP2_UPD   = 5;
    localparam int CTL_W          = 6;

    // Event bit order inside each generator's group of status bits
    localparam int EVT_ZERO = 0;
    localparam int EVT_LOAD = 1;
    localparam int EVT_CMP1 = 2;
    localparam int EVT_CMP2 = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [CNT_W-1:0] CNT_RST   = 16'h0000;
    localparam logic [CTL_W-1:0] CTL_RST   = 6'h00;
    localparam logic [EVT_W-1:0] EVT_RST   = 12'h000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

    typedef enum logic [0:0] {
        PWMCC_DIR_DOWN = 1'b0,
        PWMCC_DIR_UP   = 1'b1
    } pwmcc_dir_e;

endpackage

// ===== hw/pwmcc_cmp.sv
// Double-buffered comparator with one-cycle match pulse
`timescale 1ns/1ps
`default_nettype none
module pwmcc_cmp
    import pwmcc_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // Software write
    input  wire logic             wr_stb,
    input  wire logic [CNT_W-1:0] wr_data,
    // Update control
    input  wire logic             sync_mode,
    input  wire logic             sync_armed,
    input  wire logic             at_zero,
    // Counter side
    input  wire logic             cnt_en,
    input  wire logic [CNT_W-1:0] count,
    input  wire logic [CNT_W-1:0] load_active,
    // Results
    output logic [CNT_W-1:0]      shadow,
    output logic                  match_pulse
);
    logic [CNT_W-1:0] shadow_reg;
    logic [CNT_W-1:0] active_reg;
    logic             pending_reg;
    logic             match_reg;

    // Immediate mode commits at next zero; sync mode waits for the request
    wire commit   = at_zero && pending_reg && (!sync_mode || sync_armed);
    // Above-load value never fires
    wire in_range = active_reg <= load_active;
    wire hit      = cnt_en && in_range && (count == active_reg);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            shadow_reg  <= CNT_RST;
            active_reg  <= CNT_RST;
            pending_reg <= 1'b0;
            match_reg   <= 1'b0;
        end
        else
        begin
            // A rewrite replaces the pending value outright
            if (wr_stb)
            begin
                shadow_reg  <= wr_data;
                pending_reg <= 1'b1;
            end
            else if (commit)
            begin
                pending_reg <= 1'b0;
            end
            if (commit && !wr_stb)
            begin
                active_reg <= shadow_reg;
            end
            match_reg <= hit;
        end
    end

    assign shadow      = shadow_reg;
    assign match_pulse = match_reg;

endmodule
`default_nettype wire

// ===== hw/pwmcc_gen.sv
// Generator counter with buffered load value and zero/load pulses
`timescale 1ns/1ps
`default_nettype none
module pwmcc_gen
    import pwmcc_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // Control
    input  wire logic             cnt_en,
    input  wire logic             updown,
    input  wire logic             load_sync_mode,
    input  wire logic             sync_armed,
    // Software write of the load value
    input  wire logic             wr_stb,
    input  wire logic [CNT_W-1:0] wr_data,
    // State
    output logic [CNT_W-1:0]      count,
    output logic [CNT_W-1:0]      load_shadow,
    output logic [CNT_W-1:0]      load_active,
    output logic                  at_zero,
    output logic                  zero_pulse,
    output logic                  load_pulse
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] shadow_reg;
    logic [CNT_W-1:0] active_reg;
    logic             pending_reg;
    pwmcc_dir_e       dir_reg;
    pwmcc_dir_e       dir_next;
    logic             zero_reg;
    logic             load_reg;

    wire zero_now = cnt_en && (count_reg == CNT_RST);
    wire commit   = zero_now && pending_reg && !wr_stb && (!load_sync_mode || sync_armed);
    wire [CNT_W-1:0] load_use = commit ? shadow_reg : active_reg;
    wire at_top   = count_reg >= load_use;
    wire [CNT_W-1:0] cnt_dec = count_reg - 16'h0001;
    wire [CNT_W-1:0] cnt_inc = count_reg + 16'h0001;

    // Down mode reloads after zero; up/down turns at the load value
    always_comb
    begin
        count_next = count_reg;
        dir_next   = dir_reg;
        if (!cnt_en)
        begin
            count_next = CNT_RST;
            dir_next   = PWMCC_DIR_UP;
        end
        else if (!updown)
        begin
            count_next = zero_now ? load_use : cnt_dec;
        end
        else if (dir_reg == PWMCC_DIR_UP)
        begin
            count_next = at_top ? (zero_now ? CNT_RST : cnt_dec) : cnt_inc;
            dir_next   = at_top ? PWMCC_DIR_DOWN : PWMCC_DIR_UP;
        end
        else
        begin
            count_next = zero_now ? (at_top ? CNT_RST : cnt_inc) : cnt_dec;
            dir_next   = zero_now ? PWMCC_DIR_UP : PWMCC_DIR_DOWN;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_reg   <= CNT_RST;
            dir_reg     <= PWMCC_DIR_UP;
            shadow_reg  <= CNT_RST;
            active_reg  <= CNT_RST;
            pending_reg <= 1'b0;
            zero_reg    <= 1'b0;
            load_reg    <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            dir_reg   <= dir_next;
            if (wr_stb)
            begin
                shadow_reg  <= wr_data;
                pending_reg <= 1'b1;
            end
            else if (commit)
            begin
                pending_reg <= 1'b0;
            end
            if (commit)
            begin
                active_reg <= shadow_reg;
            end
            zero_reg <= zero_now;
            // Value taking effect now, so an enable at zero gives no stale load hit
            load_reg <= cnt_en && (count_reg == load_use);
        end
    end

    assign count       = count_reg;
    assign load_shadow = shadow_reg;
    assign load_active = active_reg;
    assign at_zero     = zero_now;
    assign zero_pulse  = zero_reg;
    assign load_pulse  = load_reg;

endmodule
`default_nettype wire

// ===== sim/pwmcc_top_chk.sv
// Port assertions for the PWM compare stage
`timescale 1ns/1ps
`default_nettype none
module pwmcc_top_chk
    import pwmcc_pkg::*;
(
    // Clock and reset
    input wire logic               mclk,
    input wire logic               reset_n,
    // APB
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [ADDR_W-1:0]  paddr,
    input wire logic [DATA_W-1:0]  pwdata,
    input wire logic [DATA_W-1:0]  prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // Events
    input wire logic [NUM_GEN-1:0] zero_pulse,
    input wire logic [NUM_GEN-1:0] load_pulse,
    input wire logic [NUM_GEN-1:0] cmp1_pulse,
    input wire logic [NUM_GEN-1:0] cmp2_pulse,
    input wire logic               irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence s_access;
        psel && penable;
    endsequence
    sequence s_rd_setup;
        psel && !penable && !pwrite;
    endsequence

    property p_ready;
        pready == 1'b1;
    endproperty
    property p_err_phase;
        pslverr |-> s_access;
    endproperty
    property p_unmapped;
        s_access ##0 (paddr[11:8] != 4'h0) |-> pslverr;
    endproperty
    // Readback is captured only at a read setup
    property p_rd_hold;
        !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    property p_zero_one;
        (zero_pulse & $past(zero_pulse)) == 3'h0;
    endproperty
    property p_load_one;
        (load_pulse & $past(load_pulse)) == 3'h0;
    endproperty
    property p_cmp1_one;
        (cmp1_pulse & $past(cmp1_pulse)) == 3'h0;
    endproperty
    property p_cmp2_one;
        (cmp2_pulse & $past(cmp2_pulse)) == 3'h0;
    endproperty
    // Only a clear or a mask write can drop the interrupt
    property p_irq_fall;
        $fell(irq) |-> $past(psel && penable && pwrite);
    endproperty

    a_ready: assert property (p_ready)
        else $error("pready low");
    a_err_phase: assert property (p_err_phase)
        else $error("pslverr outside access");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    a_rd_hold: assert property (p_rd_hold)
        else $error("prdata moved without read");
    a_zero_one: assert property (p_zero_one)
        else $error("zero pulse too long");
    a_load_one: assert property (p_load_one)
        else $error("load pulse too long");
    a_cmp1_one: assert property (p_cmp1_one)
        else $error("first compare pulse too long");
    a_cmp2_one: assert property (p_cmp2_one)
        else $error("second compare pulse too long");
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq fell without write");
endmodule
`default_nettype wire

// ===== sim/pwmcc_top_bench.sv
// Self-checking bench for the PWM compare stage
`timescale 1ns/1ps
`default_nettype none
module pwmcc_top_bench
    import pwmcc_pkg::*;
;
    // ************************************************************
    // Signals
    // ************************************************************
    localparam logic [ADDR_W-1:0] CA [3] = '{12'h058, 12'h098, 12'h0d8};
    logic               mclk;
    logic               reset_n;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [ADDR_W-1:0]  paddr;
    logic [DATA_W-1:0]  pwdata;
    logic [DATA_W-1:0]  prdata;
    logic [DATA_W-1:0]  q;
    logic               pready;
    logic               pslverr;
    logic               e;
    logic               irq;
    logic [NUM_GEN-1:0] zero_pulse;
    logic [NUM_GEN-1:0] load_pulse;
    logic [NUM_GEN-1:0] cmp1_pulse;
    logic [NUM_GEN-1:0] cmp2_pulse;
    int                 fail_count;
    int                 samples_checked;
    int                 d;

    pwmcc_top uut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .zero_pulse(zero_pulse),
        .load_pulse(load_pulse), .cmp1_pulse(cmp1_pulse), .cmp2_pulse(cmp2_pulse),
        .irq(irq));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A spare edge at the end keeps psel from being driven twice in one step
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wait_zero(input int g);
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (zero_pulse[g] !== 1'b1 && n < 100);
    endtask

    // Cycles from a zero pulse to the chosen pulse
    task automatic gap(input int g, input int w, output int k);
        logic p;
        wait_zero(g);
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
            p = (w == 0) ? cmp1_pulse[g] : (w == 1) ? cmp2_pulse[g] : load_pulse[g];
        end
        while (p !== 1'b1 && k < 100);
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ************************************************************
    // Clock, watchdog, tests
    // ************************************************************
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        #100000;
        fail_count++;
        results();
    end

    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fail_count = 0;
        samples_checked = 0;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        for (int g = 0; g < NUM_GEN; g++)
        begin
            apb(0, CA[g] - 12'h004, 0);
            chk(q, 0);
            apb(1, CA[g] - 12'h004, 32'hffff_ffff);
            apb(0, CA[g] - 12'h004, 0);
            chk(q, 0);
            apb(0, CA[g], 0);
            chk(q, 0);
            apb(0, CA[g] + 12'h004, 0);
            chk(q, 0);
        end
        apb(0, 12'h100, 0);
        chk({31'h0, e}, 1);
        chk(q, 0);
        $display("Test reset and map finished");
        for (int g = 0; g < NUM_GEN; g++)
        begin
            apb(1, CA[g] - 12'h008, 10 + g);
            apb(1, CA[g], 4);
            apb(1, CA[g] + 12'h004, 11 + g);
            apb(1, CA[g] - 12'h018, 1);
        end
        for (int g = 0; g < NUM_GEN; g++)
        begin
            gap(g, 0, d);
            chk(d, 7 + g);
            d = 0;
            repeat (40)
            begin
                @(posedge mclk);
                d += (cmp2_pulse[g] === 1'b1) ? 1 : 0;
            end
            chk(d, 0);
        end
        apb(0, CA[0] - 12'h004, 0);
        chk({16'h0, q[31:16]}, 0);
        chk(32'(q[15:0] <= 16'd10), 1);
        $display("Test compare and limit finished");
        wait_zero(0);
        apb(1, CA[0], 7);
        gap(0, 0, d);
        chk(d, 4);
        wait_zero(0);
        apb(1, CA[0] + 12'h004, 10);
        gap(0, 1, d);
        chk(d, 1);
        wait_zero(1);
        apb(1, CA[1] - 12'h018, 32'h0000_0011);
        apb(1, CA[1], 3);
        gap(1, 0, d);
        chk(d, 8);
        wait_zero(1);
        apb(1, CA[1], 5);
        apb(1, CA[1], 6);
        apb(1, 12'h000, 32'h0000_0002);
        gap(1, 0, d);
        chk(d, 6);
        apb(0, CA[1], 0);
        chk(q, 6);
        apb(0, 12'h000, 0);
        chk(q, 0);
        wait_zero(2);
        apb(1, CA[2] + 12'h004, 2);
        gap(2, 1, d);
        chk(d, 11);
        wait_zero(2);
        apb(1, CA[2] - 12'h018, 32'h0000_0021);
        apb(1, CA[2] + 12'h004, 5);
        gap(2, 1, d);
        chk(d, 11);
        wait_zero(2);
        apb(1, 12'h000, 32'h0000_0004);
        gap(2, 1, d);
        chk(d, 8);
        $display("Test update modes finished");
        wait_zero(0);
        apb(1, CA[0] - 12'h008, 8);
        gap(0, 0, d);
        chk(d, 2);
        gap(0, 2, d);
        chk(d, 1);
        wait_zero(0);
        apb(1, CA[0] - 12'h018, 3);
        gap(0, 2, d);
        chk(d, 8);
        $display("Test load and direction finished");
        chk({31'h0, irq}, 0);
        apb(0, 12'h004, 0);
        chk({31'h0, q[2]}, 1);
        apb(1, 12'h008, 32'h0000_0004);
        chk({31'h0, irq}, 1);
        apb(1, CA[0] - 12'h018, 0);
        apb(1, 12'h004, 32'h0000_0004);
        apb(0, 12'h004, 0);
        chk({31'h0, q[2]}, 0);
        chk({31'h0, irq}, 0);
        $display("Test interrupt finished");
        results();
    end
endmodule

bind pwmcc_top pwmcc_top_chk u_chk (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .zero_pulse(zero_pulse),
    .load_pulse(load_pulse), .cmp1_pulse(cmp1_pulse), .cmp2_pulse(cmp2_pulse),
    .irq(irq));
`default_nettype wire
